// ==== hdl/sec_core.sv ====
// Command interface of a 1-kbit serial EEPROM, array held in flip-flops.
// Assumes the bus pins are asynchronous to CORE_CLK and that RESET is the
// supply-detect reset, held until the supply is stable.
// Functional notes
// - Sample data input on serial clock rise.
// - Start bit one, then opcode, address, data.
// - Stopped serial clock freezes decoder state; programming timer runs on.
// - Chip select low ends transaction, standby.
// - Read: dummy zero, then addressed word.
// - Read output changes on serial clock rise.
// - Read continues to next address, wraps.
// - Layout input picks x16 or x8 array.
// - Write enable latch clear after power-up.
// - Programming ignored unless write enable set.
// - Write enable holds until lock instruction.
// - Lock instruction clears write enable latch.
// - Select fall starts self-timed programming cycle.
// - Status on output after select rises again.
// - No status if select rises after cycle.
// - Programming cycle lasts at most 5 ms.
// - Fill writes pattern to every location.
// - Erase sets addressed location, reports status.
// - Clear sets whole array to ones.
// - Opcode encoding and exact bit counts.
// - Instructions ignored until reset released.
`timescale 1ns/1ns
`default_nettype none
module sec_core import sec_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
)(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CHIP_SELECT,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic DATA_IN,
  input wire logic LAYOUT_SELECT,
  output logic DATA_OUT,
  output logic DATA_OUT_OE
);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  logic [3:0] pin_s;
  logic cs_s, sk_s, din_s, layout_s;
  logic sk_d_reg, cs_d_reg;
  logic sk_edge, cs_fall, cs_rise;

  sec_state_t state_reg;
  logic [4:0] cnt_reg;
  logic [1:0] op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [WORD_W-1:0] data_reg;
  logic x16_reg;
  logic wen_reg;
  logic busy_reg;
  logic [TW-1:0] timer_reg;
  sec_prog_t pend_reg;
  logic stat_reg;
  logic dout_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [4:0] bits_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [WORD_W-1:0] mem_reg [NWORDS];

  logic [ADDR_W-1:0] addr_nx;
  logic [1:0] ext_nx, ext_now;
  logic addr_last, prog_go, prog_done;
  sec_prog_t prog_kind;
  logic [5:0] wi;
  logic [WORD_W-1:0] fill_word, put_word, fetch_word, aligned;
  logic fifo_in_ready, fifo_out_valid, pop;
  logic [WORD_W-1:0] fifo_out_data;

  sec_sync #(.W(4)) u_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .d({CHIP_SELECT, SERIAL_CLOCK_IN, DATA_IN, LAYOUT_SELECT}),
    .q(pin_s)
  );

  assign cs_s = pin_s[3];
  assign sk_s = pin_s[2];
  assign din_s = pin_s[1];
  assign layout_s = pin_s[0];

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      sk_d_reg <= 1'b0;
      cs_d_reg <= 1'b0;
    end else begin
      sk_d_reg <= sk_s;
      cs_d_reg <= cs_s;
    end
  end

  // Bits are taken only on a serial clock rise with select high.
  assign sk_edge = sk_s && !sk_d_reg && cs_s;
  assign cs_fall = cs_d_reg && !cs_s;
  assign cs_rise = cs_s && !cs_d_reg;

  assign addr_nx = {addr_reg[ADDR_W-2:0], din_s};
  assign ext_nx = x16_reg ? addr_nx[5:4] : addr_nx[6:5];
  assign ext_now = x16_reg ? addr_reg[5:4] : addr_reg[6:5];
  assign addr_last = sk_edge && state_reg == ST_ADDR && cnt_reg == 5'h00;

  always_comb begin
    case (op_reg)
      OP_WRITE: prog_kind = PG_WRITE;
      OP_ERASE: prog_kind = PG_ERASE;
      OP_EXT: begin
        if (ext_now == EXT_FILL) begin
          prog_kind = PG_FILL;
        end else if (ext_now == EXT_CLEAR) begin
          prog_kind = PG_CLEAR;
        end else begin
          prog_kind = PG_NONE;
        end
      end
      default: prog_kind = PG_NONE;
    endcase
  end

  // Decoder. With select high and no serial clock rise nothing here moves,
  // so the serial clock may stop at any point; a start bit while busy is dropped.
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      op_reg <= 2'h0;
      addr_reg <= '0;
      data_reg <= '0;
      x16_reg <= 1'b1;
    end else if (!cs_s) begin
      state_reg <= ST_IDLE;
    end else if (sk_edge) begin
      case (state_reg)
        ST_IDLE: begin
          if (din_s && !busy_reg) begin
            state_reg <= ST_OPC;
            cnt_reg <= OP_BITS - 5'h01;
            x16_reg <= layout_s;
          end
        end
        ST_OPC: begin
          op_reg <= {op_reg[0], din_s};
          if (cnt_reg == 5'h00) begin
            state_reg <= ST_ADDR;
            cnt_reg <= (x16_reg ? ADDR_BITS_X16 : ADDR_BITS_X8) - 5'h01;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        ST_ADDR: begin
          addr_reg <= x16_reg ? {1'b0, addr_nx[5:0]} : addr_nx;
          if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
          end else if (op_reg == OP_READ) begin
            state_reg <= ST_READ;
          end else if (op_reg == OP_WRITE ||
                       (op_reg == OP_EXT && ext_nx == EXT_FILL)) begin
            state_reg <= ST_DATA;
            cnt_reg <= (x16_reg ? DATA_BITS_X16 : DATA_BITS_X8) - 5'h01;
          end else begin
            state_reg <= ST_DONE;
          end
        end
        ST_DATA: begin
          data_reg <= {data_reg[WORD_W-2:0], din_s};
          if (cnt_reg == 5'h00) begin
            state_reg <= ST_DONE;
          end else begin
            cnt_reg <= cnt_reg - 5'h01;
          end
        end
        // One clock too many voids a programming instruction.
        ST_DONE: state_reg <= ST_OVER;
        ST_READ: state_reg <= ST_READ;
        ST_OVER: state_reg <= ST_OVER;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      wen_reg <= 1'b0;
    end else if (addr_last && op_reg == OP_EXT) begin
      if (ext_nx == EXT_ENABLE) begin
        wen_reg <= 1'b1;
      end else if (ext_nx == EXT_LOCK) begin
        wen_reg <= 1'b0;
      end
    end
  end

  // Only a complete instruction, exactly counted, starts a cycle.
  assign prog_go = cs_fall && state_reg == ST_DONE && wen_reg &&
                   !busy_reg && prog_kind != PG_NONE;
  assign prog_done = busy_reg && timer_reg == TW'(PROG_CYCLES - 1);

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      busy_reg <= 1'b0;
      timer_reg <= '0;
      pend_reg <= PG_NONE;
    end else if (prog_go) begin
      busy_reg <= 1'b1;
      timer_reg <= '0;
      pend_reg <= prog_kind;
    end else if (prog_done) begin
      busy_reg <= 1'b0;
      pend_reg <= PG_NONE;
    end else if (busy_reg) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // The array changes only when the cycle ends; decoder registers are
  // frozen meanwhile because start bits are refused while busy.
  assign wi = x16_reg ? addr_reg[5:0] : addr_reg[6:1];
  assign fill_word = x16_reg ? data_reg : {2{data_reg[BYTE_W-1:0]}};

  always_comb begin
    put_word = (pend_reg == PG_WRITE) ? data_reg : '1;
    if (!x16_reg) begin
      if (addr_reg[0]) begin
        put_word = {put_word[BYTE_W-1:0], mem_reg[wi][BYTE_W-1:0]};
      end else begin
        put_word = {mem_reg[wi][WORD_W-1:BYTE_W], put_word[BYTE_W-1:0]};
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (prog_done) begin
      case (pend_reg)
        PG_WRITE, PG_ERASE: mem_reg[wi] <= put_word;
        PG_FILL: begin
          for (int i = 0; i < NWORDS; i++) begin
            mem_reg[i] <= fill_word;
          end
        end
        PG_CLEAR: begin
          for (int i = 0; i < NWORDS; i++) begin
            mem_reg[i] <= '1;
          end
        end
        default: ;
      endcase
    end
  end

  // Read prefetch: words run ahead of the shifter into the FIFO, which
  // fills and then stalls the fetch pointer until a word is shifted out.
  assign fetch_word = x16_reg ? mem_reg[rd_addr_reg[5:0]] :
                      (rd_addr_reg[0] ?
                       {8'h00, mem_reg[rd_addr_reg[6:1]][WORD_W-1:BYTE_W]} :
                       {8'h00, mem_reg[rd_addr_reg[6:1]][BYTE_W-1:0]});

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rd_addr_reg <= '0;
    end else if (addr_last && op_reg == OP_READ) begin
      rd_addr_reg <= x16_reg ? {1'b0, addr_nx[5:0]} : addr_nx;
    end else if (state_reg == ST_READ && fifo_in_ready) begin
      if (x16_reg) begin
        rd_addr_reg <= {1'b0, rd_addr_reg[5:0] + 6'h01};
      end else begin
        rd_addr_reg <= rd_addr_reg + 7'h01;
      end
    end
  end

  sec_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .rst(RESET),
    .flush(state_reg != ST_READ),
    .in_valid(state_reg == ST_READ),
    .in_ready(fifo_in_ready),
    .in_data(fetch_word),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  assign pop = sk_edge && state_reg == ST_READ && bits_reg == 5'h00;
  assign aligned = x16_reg ? fifo_out_data :
                   {fifo_out_data[BYTE_W-1:0], 8'h00};

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      stat_reg <= 1'b0;
    end else if (!cs_s) begin
      stat_reg <= 1'b0;
    end else if (cs_rise && busy_reg) begin
      stat_reg <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dout_reg <= 1'b0;
      shift_reg <= '0;
      bits_reg <= 5'h00;
    end else if (addr_last && op_reg == OP_READ) begin
      dout_reg <= 1'b0;
      bits_reg <= 5'h00;
    end else if (pop) begin
      dout_reg <= fifo_out_valid && aligned[WORD_W-1];
      shift_reg <= {aligned[WORD_W-2:0], 1'b0};
      bits_reg <= (x16_reg ? DATA_BITS_X16 : DATA_BITS_X8) - 5'h01;
    end else if (sk_edge && state_reg == ST_READ) begin
      dout_reg <= shift_reg[WORD_W-1];
      shift_reg <= {shift_reg[WORD_W-2:0], 1'b0};
      bits_reg <= bits_reg - 5'h01;
    end else if (stat_reg || (cs_rise && busy_reg)) begin
      dout_reg <= !busy_reg;
    end
  end

  assign DATA_OUT = dout_reg;
  assign DATA_OUT_OE = state_reg == ST_READ || stat_reg;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  wen_lock_a: assert property (addr_last && op_reg == OP_EXT &&
      ext_nx == EXT_LOCK |=> !wen_reg ##1 !prog_go)
    else $error("lock did not clear write enable");
  wen_set_a: assert property (addr_last && op_reg == OP_EXT &&
      ext_nx == EXT_ENABLE |=> wen_reg)
    else $error("enable did not set write enable");
  locked_prog_a: assert property (!busy_reg && !wen_reg |=>
      !busy_reg)
    else $error("programming started while locked");
  prog_start_a: assert property (prog_go |=> busy_reg &&
      timer_reg == '0)
    else $error("select fall did not start programming");
  dummy_zero_a: assert property (addr_last && op_reg == OP_READ |=>
      DATA_OUT_OE && !DATA_OUT)
    else $error("read did not begin with a zero bit");
  frozen_a: assert property (cs_s && !sk_edge &&
      !cs_fall |=> $stable(state_reg) && $stable(cnt_reg))
    else $error("decoder moved without a clock edge");
  read_edge_a: assert property (state_reg == ST_READ &&
      !addr_last && $past(state_reg) == ST_READ && !$past(sk_edge) |->
      $stable(dout_reg))
    else $error("read output changed off a clock edge");
  prog_end_a: assert property (prog_done |=> !busy_reg)
    else $error("programming cycle overran");
  standby_a: assert property (!cs_s |=> state_reg == ST_IDLE)
    else $error("select low did not return to standby");
  late_stat_a: assert property (cs_rise && !busy_reg |=>
      !stat_reg)
    else $error("status shown after cycle ended");
  stat_val_a: assert property (stat_reg && $past(stat_reg) |->
      DATA_OUT_OE && DATA_OUT == !$past(busy_reg))
    else $error("status bit wrong");

  read_cov: cover property (addr_last && op_reg == OP_READ);
  prog_cov: cover property (prog_go);
  ready_cov: cover property (stat_reg && busy_reg ##1 stat_reg && !busy_reg);
  full_cov: cover property (state_reg == ST_READ && !fifo_in_ready);
endmodule
`default_nettype wire

// ==== pkg/sec_pkg.sv ====
// Shared constants and types of the serial EEPROM command interface.
// Assumes a 20 MHz core clock that samples every pin of the three-wire bus.
package sec_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES_DEF = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int NWORDS = 64;
  localparam int ADDR_W = 7;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] OP_BITS = 5'h02;
  localparam logic [4:0] ADDR_BITS_X16 = 5'h06;
  localparam logic [4:0] ADDR_BITS_X8 = 5'h07;
  localparam logic [4:0] DATA_BITS_X16 = 5'h10;
  localparam logic [4:0] DATA_BITS_X8 = 5'h08;
  localparam logic [1:0] OP_EXT = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_FILL = 2'h1;
  localparam logic [1:0] EXT_CLEAR = 2'h2;
  localparam logic [1:0] EXT_ENABLE = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_READ, ST_DONE, ST_OVER
  } sec_state_t;
  typedef enum logic [2:0] {
    PG_NONE, PG_WRITE, PG_ERASE, PG_FILL, PG_CLEAR
  } sec_prog_t;
endpackage

// ==== hdl/sec_sync.sv ====
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ns
`default_nettype none
module sec_sync #(
  parameter int W = 1
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/sec_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush.
// Assumes one clock; flush wins over a push in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module sec_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != (PW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rp_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/sec_host.sv ====
// Host model that drives the three-wire serial bus of the EEPROM core.
// Assumes a free-running core clock; pins move only at its falling edge.
`timescale 1ns/1ns
`default_nettype none
module sec_host (
  input wire logic clk,
  input wire logic dout,
  input wire logic dout_oe,
  output logic cs,
  output logic sk,
  output logic di,
  output logic line
);
  int stretch = 4;
  logic last = 1'b0;
  // A released output shows the inverse of its last level, so a stale
  // bit can never pass for a fresh one.
  always @(posedge clk) if (dout_oe) last <= dout;
  assign line = dout_oe ? dout : ~last;
  initial begin
    cs = 1'b0;
    sk = 1'b0;
    di = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Select only moves while the serial clock rests low.
  task automatic raise_cs();
    pause(4);
    cs = 1'b1;
    pause(8);
  endtask
  // Dropping select ends the frame well before any further rise.
  task automatic drop_cs();
    pause(4);
    cs = 1'b0;
    pause(8);
  endtask
  // One serial clock rise; data stays as the caller left it.
  task automatic tick();
    pause(stretch);
    sk = 1'b1;
    pause(4);
    sk = 1'b0;
  endtask
  // Data is set in the low phase and held through the rise.
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      di = v[i];
      tick();
    end
  endtask
  task automatic fetch(input int n, output logic [16:0] q);
    q = '0;
    for (int i = 0; i < n; i++) begin
      pause(stretch);
      q = {q[15:0], line};
      sk = 1'b1;
      pause(4);
      sk = 1'b0;
    end
  endtask
  // No new instruction goes out before ready is seen or 400 cycles pass.
  task automatic wait_ready(output int cyc);
    cyc = 0;
    while (line !== 1'b1 && cyc < 400) begin
      pause(1);
      cyc++;
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_serial_eeprom_command_interface.sv ====
// Self-checking bench of the EEPROM core with a host model and a memory
// model; assumes the core's programming time is shortened by parameter.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_eeprom_command_interface;
  import sec_pkg::*;
  localparam int PROG = 50;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic layout = 1'b1;
  logic cs, sk, di, line, dout, oe;
  logic [15:0] mem [64];
  logic [31:0] seed = 32'hbe9a;
  logic [15:0] d;
  logic [6:0] wa [4] = '{7'h00, 7'h3f, 7'h3e, 7'h11};
  bit wen = 0;
  bit x8 = 0;
  int mismatches = 0;
  int cmp_count = 0;
  always #25 core_clk = ~core_clk;
  sec_core #(.PROG_CYCLES(PROG)) sec_core_i (.CORE_CLK(core_clk),
    .RESET(reset), .CHIP_SELECT(cs), .SERIAL_CLOCK_IN(sk), .DATA_IN(di),
    .LAYOUT_SELECT(layout), .DATA_OUT(dout), .DATA_OUT_OE(oe));
  sec_host sec_host_i (.clk(core_clk), .dout(dout), .dout_oe(oe),
    .cs(cs), .sk(sk), .di(di), .line(line));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] mval(input int a);
    if (!x8) return mem[a];
    return a[0] ? {8'h00, mem[a >> 1][15:8]} : {8'h00, mem[a >> 1][7:0]};
  endfunction
  function automatic logic [6:0] aext(input logic [1:0] c);
    return x8 ? {c, 5'h00} : {1'b0, c, 4'h0};
  endfunction
  task automatic mput(input int a, input logic [15:0] v);
    if (!wen) return;
    if (!x8) mem[a] = v;
    else if (a[0]) mem[a >> 1][15:8] = v[7:0];
    else mem[a >> 1][7:0] = v[7:0];
  endtask
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Random low-phase lengths stall the serial clock mid-instruction.
  task automatic instr(input logic [1:0] op, input logic [6:0] a,
                       input logic [15:0] v, input bit nd);
    int aw = x8 ? ADDR_BITS_X8 : ADDR_BITS_X16;
    int dw = x8 ? DATA_BITS_X8 : DATA_BITS_X16;
    sec_host_i.stretch = 4 + int'(xs() % 32'h8);
    sec_host_i.send({13'h0000, 1'b1, op}, 3);
    sec_host_i.send({9'h000, a}, aw);
    if (nd) sec_host_i.send(v, dw);
  endtask
  task automatic ext(input logic [1:0] c);
    sec_host_i.raise_cs();
    instr(OP_EXT, aext(c), 16'h0000, 0);
    sec_host_i.drop_cs();
    wen = (c == EXT_ENABLE);
  endtask
  task automatic prog(input logic [1:0] op, input logic [6:0] a,
                      input logic [15:0] v, input bit nd);
    int cyc;
    sec_host_i.raise_cs();
    instr(op, a, v, nd);
    sec_host_i.drop_cs();
    sec_host_i.raise_cs();
    check("status enable", {15'h0000, oe}, {15'h0000, wen});
    if (wen) begin
      check("busy", {15'h0000, line}, 16'h0000);
      sec_host_i.wait_ready(cyc);
      check("ready", {15'h0000, line}, 16'h0001);
      // About twenty cycles of the run have passed before counting.
      check("ready time", {15'h0000, cyc < PROG}, 16'h0001);
      sec_host_i.drop_cs();
      sec_host_i.raise_cs();
      check("late status", {15'h0000, oe}, 16'h0000);
    end
    sec_host_i.drop_cs();
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    logic [16:0] q;
    logic [15:0] expq [$];
    int w = x8 ? DATA_BITS_X8 : DATA_BITS_X16;
    for (int i = 0; i < n; i++) begin
      expq.push_back(mval((a + i) % (x8 ? 128 : 64)));
    end
    sec_host_i.raise_cs();
    instr(OP_READ, a, 16'h0000, 0);
    sec_host_i.fetch(w + 1, q);
    check("dummy", {15'h0000, q[w]}, 16'h0000);
    for (int i = 0; i < n; i++) begin
      if (i > 0) sec_host_i.fetch(w, q);
      check("read", q[15:0], expq.pop_front());
    end
    sec_host_i.drop_cs();
    check("idle output", {15'h0000, oe}, 16'h0000);
  endtask
  task automatic close_out();
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) reset = 1'b0;
    prog(OP_WRITE, 7'h05, 16'h1234, 1);
    ext(EXT_ENABLE);
    d = xs();
    prog(OP_EXT, aext(EXT_FILL), d, 1);
    foreach (mem[i]) mem[i] = d;
    foreach (wa[k]) begin
      d = xs();
      prog(OP_WRITE, wa[k], d, 1);
      mput(wa[k], d);
    end
    // One rise too many must void the write and keep the fill word.
    sec_host_i.raise_cs();
    instr(OP_WRITE, 7'h20, ~mem[32], 1);
    sec_host_i.tick();
    sec_host_i.drop_cs();
    sec_host_i.raise_cs();
    check("extra rise", {15'h0000, oe}, 16'h0000);
    sec_host_i.drop_cs();
    rd(7'h3e, 3);
    rd(7'h20, 1);
    prog(OP_ERASE, 7'h3f, 16'h0000, 0);
    mput(63, 16'hffff);
    ext(EXT_LOCK);
    prog(OP_WRITE, 7'h3f, 16'h0000, 1);
    rd(7'h3f, 1);
    ext(EXT_ENABLE);
    x8 = 1;
    layout = 1'b0;
    d = xs();
    prog(OP_WRITE, 7'h7f, d, 1);
    mput(127, d);
    rd(7'h7e, 3);
    prog(OP_EXT, aext(EXT_CLEAR), 16'h0000, 0);
    foreach (mem[i]) mem[i] = 16'hffff;
    x8 = 0;
    layout = 1'b1;
    rd(7'h0a, 2);
    ext(EXT_LOCK);
    close_out();
  end
endmodule
`default_nettype wire
